// [src/kst_pkg.sv]
package kst_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_HZ = 50_000_000;
	localparam int HOLD_S = 10;
	localparam int HOLD_CYC = HOLD_S * CLK_HZ;
	localparam int DEB_MS = 20;
	localparam int DEB_CYC = DEB_MS * (CLK_HZ / 1000);
	localparam int RAPID_HZ = 4;
	localparam int RAPID_HALF_CYC = CLK_HZ / (2 * RAPID_HZ);
	localparam logic [1:0] SLOW_LAST = 2'h3;

	// ==========================================================
	// Register map
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam int CFG_W = 11;
	localparam int CFG_LO_W = 8;
	localparam int CMD_OFF_LSB = 0;
	localparam int STAT_PAD_W = 20;
	localparam int NPART = 2;
	localparam int NTRIG = 7;

	// ==========================================================
	// Keyswitch modes and trigger function selections
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_P1 = 4'h1;
	localparam logic [3:0] MODE_P2 = 4'h2;
	localparam logic [3:0] MODE_FIRE = 4'h9;
	localparam logic [1:0] TSEL_SOUNDER = 2'h0;
	localparam logic [1:0] TSEL_KSLED = 2'h1;
	localparam logic [1:0] TSEL_COMM = 2'h2;
	localparam logic [7:0] KS_USER = 8'h00;

	// ==========================================================
	// Trigger header output index (out 1 is index 0)
	localparam int TRG_O1 = 0;
	localparam int TRG_O2 = 1;
	localparam int TRG_O3 = 2;
	localparam int TRG_O4 = 3;
	localparam int TRG_O5 = 4;
	localparam int TRG_O6 = 5;
	localparam int TRG_O7 = 6;

	// ==========================================================
	// Types
	typedef struct packed {
		logic aux_alarm;
		logic [1:0] part_en;
		logic rpt_en;
		logic printer_sel;
		logic [1:0] trig_sel;
		logic [3:0] ks_mode;
	} kst_cfg_t;

	localparam kst_cfg_t CFG_RST = 11'h000;

	typedef struct packed {
		logic [1:0] alarm;
		logic [1:0] fire;
		logic [1:0] burg;
		logic [1:0] spanic;
		logic [1:0] duress;
		logic [1:0] superv;
		logic [1:0] trouble;
		logic [1:0] fault;
	} kst_cond_t;

	typedef struct packed {
		logic tx_exhaust;
		logic tx_ok;
		logic [1:0] line_fault;
	} kst_comm_t;

	typedef enum logic [1:0] {RPT_AWAY, RPT_STAY, RPT_DISARM} kst_rpt_t;

	typedef enum logic [1:0] {KS_IDLE, KS_DEB, KS_HELD, KS_WAIT} kst_ks_t;

endpackage

// [src/kst_keyswitch.sv]
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ns
// Summary of operation
// - Disarmed, no alarm: short arms away; hold over 10 s arms stay.
// - Armed without alarm: a further short disarms the partition.
// - Arming by keyswitch refused while any unbypassed zone is faulted.
// - Alarm present: short silences bell and keypad, disarms, sets memory.
// - Next short after silence clears memory and pulses smoke power reset.
// - Fire-silence mode: short turns off bells and alarm relay during fire.
// - Fire-silence mode: new fire alarm reactivates silenced bells.
// - After fire silence, burglary cannot sound bell until user off.
// - Fire-silence mode: short without fire alarm changes nothing.
// - LEDs: off/off not ready, green ready, red steady/slow/rapid states.
// - Keyswitch arm and disarm are reported as user 0 when enabled.
// - Mains indicator follows Mains_indicator presence.
// - Comm fail set on exhausted attempts; cleared by off after success.
// - Line fault indicators clear only after fault gone and user off.
// - Comm indicators on outputs 1, 3, 4, 5 only with selection 2.
// - Aux triggers common to partitions, gated by per-partition enable.
// - Open/close trigger low when all enabled armed, else high.
// - Other triggers rest low, rise on condition in an enabled partition.
// - Fire and burglary triggers latch until user off in each partition.
// - Silent panic latches; duress gives only a momentary trigger.
// - Supervisory and trouble hold until fault gone and user off.
// - Printer selection takes input 1 and output 2 over trigger function.
// - Tamper open disables keyswitch until keypad disarm of its partition.
// - Selection 1: outputs 1 and 5 drive keyswitch armed and ready LEDs.
module kst_keyswitch #(
	parameter int unsigned DEB_CYC = kst_pkg::DEB_CYC,
	parameter int unsigned HOLD_CYC = kst_pkg::HOLD_CYC,
	parameter int unsigned FLASH_HALF_CYC = kst_pkg::RAPID_HALF_CYC
) (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Pins
	input wire logic ks_short_i,
	input wire logic ks_tamper_i,
	input wire logic ac_present_i,
	input wire logic trig_in1_i,
	// Panel logic
	input wire kst_pkg::kst_cond_t cond_i,
	input wire kst_pkg::kst_comm_t comm_i,
	input wire logic sounder_i,
	input wire logic printer_txd_i,
	// Trigger header and keyswitch LEDs
	output logic [6:0] trigger_header_o,
	output logic led_red_o,
	output logic led_green_o,
	// Bells, sounds, detector power
	output logic bell_off_o,
	output logic aux_relay_off_o,
	output logic burg_bell_block_o,
	output logic [1:0] sound_silence_o,
	output logic smoke_reset_o,
	// Reports and input 1
	output logic rpt_stb_o,
	output kst_pkg::kst_rpt_t rpt_kind_o,
	output logic [7:0] rpt_user_o,
	output logic printer_rxd_o,
	output logic aux_in_o
);

	localparam logic [31:0] DEB_LAST = 32'(DEB_CYC - 1);
	localparam logic [31:0] HOLD_LAST = 32'(HOLD_CYC - 1);
	localparam logic [31:0] FLASH_LAST = 32'(FLASH_HALF_CYC - 1);

	function automatic logic [1:0] part_mask(input logic [3:0] mode);
		part_mask = (mode == kst_pkg::MODE_P1) ? 2'h1 : (mode == kst_pkg::MODE_P2) ? 2'h2 : 2'h3;
	endfunction

	// ==========================================================
	// Pin synchronisers
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic ks_s;
	logic tmp_s;
	logic ac_s;
	logic in1_s;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
		end
		else if (ce_i)
		begin
			pin_s1 <= {trig_in1_i, ac_present_i, ks_tamper_i, ks_short_i};
			pin_s2 <= pin_s1;
		end
	end

	assign {in1_s, ac_s, tmp_s, ks_s} = pin_s2;

	// ==========================================================
	// Wishbone slave
	kst_pkg::kst_cfg_t cfg_reg;
	kst_pkg::kst_cfg_t cfg_next;
	logic ack_next;
	logic wr_go;
	logic [31:0] rd_next;
	logic [31:0] stat_w;
	logic [1:0] off_v;
	wire logic req = wb_cyc_i & wb_stb_i;
	wire logic hit_cfg = wb_adr_i[7:2] == kst_pkg::OFS_CONFIG[7:2];
	wire logic hit_cmd = wb_adr_i[7:2] == kst_pkg::OFS_CMD[7:2];
	wire logic hit_stat = wb_adr_i[7:2] == kst_pkg::OFS_STATUS[7:2];

	assign ack_next = req & ~wb_ack_o;
	assign wr_go = req & wb_ack_o & wb_we_i;
	assign cfg_next[7:0] = (wr_go & hit_cfg & wb_sel_i[0]) ? wb_dat_i[7:0] : cfg_reg[7:0];
	assign cfg_next[10:8] = (wr_go & hit_cfg & wb_sel_i[1]) ? wb_dat_i[10:8] : cfg_reg[10:8];
	assign off_v = (wr_go & hit_cmd & wb_sel_i[0]) ? wb_dat_i[kst_pkg::CMD_OFF_LSB +: 2] : 2'h0;
	assign rd_next = hit_cfg ? {21'h0, cfg_reg} : hit_stat ? stat_w : 32'h0;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			cfg_reg <= kst_pkg::CFG_RST;
		end
		else if (ce_i)
		begin
			wb_ack_o <= ack_next;
			wb_dat_o <= rd_next;
			cfg_reg <= cfg_next;
		end
	end

	// ==========================================================
	// Keyswitch debounce and hold timing
	kst_pkg::kst_ks_t st_reg;
	kst_pkg::kst_ks_t st_next;
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic ev_short;
	logic ev_long;

	always_comb
	begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		ev_short = 1'b0;
		ev_long = 1'b0;
		unique case (st_reg)
			kst_pkg::KS_IDLE:
			begin
				cnt_next = 32'h0;
				if (ks_s)
					st_next = kst_pkg::KS_DEB;
			end
			kst_pkg::KS_DEB:
			begin
				if (!ks_s)
					st_next = kst_pkg::KS_IDLE;
				else if (cnt_reg == DEB_LAST)
				begin
					st_next = kst_pkg::KS_HELD;
					cnt_next = 32'h0;
				end
				else
					cnt_next = cnt_reg + 32'h1;
			end
			kst_pkg::KS_HELD:
			begin
				if (!ks_s)
				begin
					ev_short = 1'b1;
					st_next = kst_pkg::KS_IDLE;
				end
				else if (cnt_reg == HOLD_LAST)
				begin
					ev_long = 1'b1;
					st_next = kst_pkg::KS_WAIT;
				end
				else
					cnt_next = cnt_reg + 32'h1;
			end
			kst_pkg::KS_WAIT:
			begin
				if (!ks_s)
					st_next = kst_pkg::KS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_reg <= kst_pkg::KS_IDLE;
			cnt_reg <= 32'h0;
		end
		else if (ce_i)
		begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
		end
	end

	// ==========================================================
	// Partition actions and alarm latches
	logic ks_lock_reg;
	logic ks_lock_next;
	logic [1:0] armed_reg, armed_next, stay_reg, stay_next, mem_reg, mem_next;
	logic [1:0] sil_reg, sil_next, hit_v, alm_v, clr_v, dis_v, arm_v;
	logic [1:0] fire_lat, fire_lat_n, burg_lat, burg_lat_n, sp_lat, sp_lat_n;
	logic [1:0] sup_lat, sup_lat_n, tr_lat, tr_lat_n;
	wire logic [1:0] pmask = part_mask(cfg_reg.ks_mode);
	wire logic part_mode = (cfg_reg.ks_mode == kst_pkg::MODE_P1) | (cfg_reg.ks_mode == kst_pkg::MODE_P2);
	wire logic mode_fire = cfg_reg.ks_mode == kst_pkg::MODE_FIRE;
	wire logic psel = cfg_reg.ks_mode == kst_pkg::MODE_P2;
	wire logic ev_ok = (ev_short | ev_long) & ~ks_lock_reg;

	assign ks_lock_next = tmp_s | (ks_lock_reg & ~(|(off_v & pmask)));

	genvar p;
	for (p = 0; p < kst_pkg::NPART; p++)
	begin : g_part
		assign hit_v[p] = ev_ok & part_mode & pmask[p];
		assign alm_v[p] = hit_v[p] & cond_i.alarm[p];
		assign clr_v[p] = hit_v[p] & ~cond_i.alarm[p] & mem_reg[p];
		assign dis_v[p] = hit_v[p] & ~cond_i.alarm[p] & ~mem_reg[p] & armed_reg[p];
		assign arm_v[p] = hit_v[p] & ~cond_i.alarm[p] & ~mem_reg[p] & ~armed_reg[p]
			& ~cond_i.fault[p];
		assign armed_next[p] = arm_v[p] | (armed_reg[p] & ~alm_v[p] & ~dis_v[p] & ~off_v[p]);
		assign stay_next[p] = arm_v[p] ? ev_long : (stay_reg[p] & armed_next[p]);
		assign mem_next[p] = alm_v[p] | (mem_reg[p] & ~clr_v[p]);
		assign sil_next[p] = alm_v[p] | (sil_reg[p] & cond_i.alarm[p]);
		assign fire_lat_n[p] = cond_i.fire[p] | (fire_lat[p] & ~off_v[p]);
		assign burg_lat_n[p] = cond_i.burg[p] | (burg_lat[p] & ~off_v[p]);
		assign sp_lat_n[p] = cond_i.spanic[p] | (sp_lat[p] & ~off_v[p]);
		assign sup_lat_n[p] = cond_i.superv[p] | (sup_lat[p] & ~off_v[p]);
		assign tr_lat_n[p] = cond_i.trouble[p] | (tr_lat[p] & ~off_v[p]);
	end

	// ==========================================================
	// Fire-silence mode
	logic [1:0] fire_prev;
	logic fire_sil_reg;
	logic burg_lock_reg;
	wire logic fire_new = |(cond_i.fire & ~fire_prev);
	wire logic fs_hit = ev_ok & mode_fire & (|cond_i.fire);
	wire logic fire_sil_next = ~fire_new & (fs_hit | fire_sil_reg);
	wire logic burg_lock_next = fs_hit | (burg_lock_reg & ~(|off_v));

	// ==========================================================
	// Communicator indicators
	logic cf_reg, ok_seen_reg;
	logic [1:0] lf_reg;
	wire logic cf_next = comm_i.tx_exhaust | (cf_reg & ~((|off_v) & ok_seen_reg));
	wire logic ok_seen_next = comm_i.tx_ok | (ok_seen_reg & ~comm_i.tx_exhaust);
	wire logic [1:0] lf_next = comm_i.line_fault | (lf_reg & ~{2{|off_v}});

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			{ks_lock_reg, armed_reg, stay_reg, mem_reg, sil_reg} <= 9'h000;
			{fire_lat, burg_lat, sp_lat, sup_lat, tr_lat} <= 10'h000;
			{fire_prev, fire_sil_reg, burg_lock_reg} <= 4'h0;
			{cf_reg, ok_seen_reg, lf_reg} <= 4'h0;
		end
		else if (ce_i)
		begin
			{ks_lock_reg, armed_reg, stay_reg, mem_reg, sil_reg} <=
				{ks_lock_next, armed_next, stay_next, mem_next, sil_next};
			{fire_lat, burg_lat, sp_lat, sup_lat, tr_lat} <=
				{fire_lat_n, burg_lat_n, sp_lat_n, sup_lat_n, tr_lat_n};
			{fire_prev, fire_sil_reg, burg_lock_reg} <= {cond_i.fire, fire_sil_next, burg_lock_next};
			{cf_reg, ok_seen_reg, lf_reg} <= {cf_next, ok_seen_next, lf_next};
		end
	end

	assign stat_w = {20'h0, ks_lock_reg, lf_reg, cf_reg, burg_lock_reg, fire_sil_reg,
		mem_reg, stay_reg, armed_reg};

	// ==========================================================
	// Flash divider and LED code
	logic [31:0] fl_cnt;
	logic [1:0] slow_cnt;
	logic rapid_reg, slow_reg;
	wire logic fl_wrap = fl_cnt == FLASH_LAST;
	wire logic red_next = part_mode & (mem_reg[psel] ? rapid_reg
		: armed_reg[psel] & (stay_reg[psel] ? slow_reg : 1'b1));
	wire logic green_next = part_mode & ~mem_reg[psel] & ~armed_reg[psel] & ~cond_i.fault[psel];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			{fl_cnt, slow_cnt, rapid_reg, slow_reg} <= 36'h0;
		end
		else if (ce_i)
		begin
			fl_cnt <= fl_wrap ? 32'h0 : fl_cnt + 32'h1;
			rapid_reg <= rapid_reg ^ fl_wrap;
			slow_cnt <= slow_cnt + {1'b0, fl_wrap};
			slow_reg <= slow_reg ^ (fl_wrap & (slow_cnt == kst_pkg::SLOW_LAST));
		end
	end

	// ==========================================================
	// Trigger header
	logic [6:0] trig_next;
	wire logic [1:0] en = cfg_reg.part_en;
	wire logic oc_t = |(en & ~armed_next);
	wire logic fire_t = |(en & fire_lat_n);
	wire logic burg_t = |(en & burg_lat_n);
	wire logic sp_t = |(en & (sp_lat_n | cond_i.duress));
	wire logic sup_t = |(en & sup_lat_n);
	wire logic tr_t = |(en & tr_lat_n);
	wire logic tsel_led = cfg_reg.trig_sel == kst_pkg::TSEL_KSLED;
	wire logic tsel_comm = cfg_reg.trig_sel == kst_pkg::TSEL_COMM;
	wire logic tsel_snd = cfg_reg.trig_sel == kst_pkg::TSEL_SOUNDER;

	assign trig_next[kst_pkg::TRG_O1] = tsel_comm ? ac_s
		: tsel_led ? red_next : fire_t;
	assign trig_next[kst_pkg::TRG_O2] = cfg_reg.printer_sel ? printer_txd_i : burg_t;
	assign trig_next[kst_pkg::TRG_O3] = tsel_comm ? cf_next : sp_t;
	assign trig_next[kst_pkg::TRG_O4] = tsel_comm ? lf_next[0] : sup_t;
	assign trig_next[kst_pkg::TRG_O5] = tsel_comm ? lf_next[1] : tsel_led ? green_next
		: tsel_snd ? sounder_i : 1'b0;
	assign trig_next[kst_pkg::TRG_O6] = tr_t;
	assign trig_next[kst_pkg::TRG_O7] = oc_t;

	// ==========================================================
	// Output flops and reports
	wire logic rpt_arm = |arm_v;
	wire logic rpt_dis = |((alm_v | dis_v) & armed_reg);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			{trigger_header_o, led_red_o, led_green_o} <= 9'h000;
			{bell_off_o, aux_relay_off_o, burg_bell_block_o, sound_silence_o, smoke_reset_o} <= 6'h00;
			{rpt_stb_o, printer_rxd_o, aux_in_o} <= 3'h2;
			rpt_kind_o <= kst_pkg::RPT_AWAY;
			rpt_user_o <= kst_pkg::KS_USER;
		end
		else if (ce_i)
		begin
			trigger_header_o <= trig_next;
			led_red_o <= red_next;
			led_green_o <= green_next;
			bell_off_o <= fire_sil_next;
			aux_relay_off_o <= fire_sil_next & cfg_reg.aux_alarm;
			burg_bell_block_o <= burg_lock_next;
			sound_silence_o <= sil_next;
			smoke_reset_o <= |clr_v;
			rpt_stb_o <= cfg_reg.rpt_en & (rpt_arm | rpt_dis);
			rpt_kind_o <= rpt_dis ? kst_pkg::RPT_DISARM : ev_long ? kst_pkg::RPT_STAY : kst_pkg::RPT_AWAY;
			rpt_user_o <= kst_pkg::KS_USER;
			printer_rxd_o <= cfg_reg.printer_sel ? in1_s : 1'b1;
			aux_in_o <= cfg_reg.printer_sel ? 1'b0 : in1_s;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_arm_away: assert property (ce_i && rpt_arm && ev_short |=>
		((armed_reg & ~stay_reg & $past(arm_v)) == $past(arm_v))) else $error("away arm missed");
	a_arm_stay: assert property (ce_i && rpt_arm && ev_long |=>
		((armed_reg & stay_reg & $past(arm_v)) == $past(arm_v))) else $error("stay arm missed");
	a_ks_disarm: assert property (ce_i && |dis_v |=> ((armed_reg & $past(dis_v)) == 2'h0))
		else $error("keyswitch disarm missed");
	a_arm_refused: assert property (ce_i && |(hit_v & cond_i.fault & ~armed_reg) |=>
		((armed_reg & $past(hit_v)) == 2'h0)) else $error("armed with faulted zone");
	a_alarm_silence: assert property (ce_i && |alm_v |=>
		((mem_reg & $past(alm_v)) == $past(alm_v)) && ((armed_reg & $past(alm_v)) == 2'h0))
		else $error("alarm silence incomplete");
	a_memory_clear: assert property (ce_i && |clr_v |=> smoke_reset_o &&
		((mem_reg & $past(clr_v)) == 2'h0)) else $error("memory clear incomplete");
	a_fire_silence: assert property (ce_i && fs_hit && !fire_new |=> bell_off_o &&
		burg_bell_block_o) else $error("fire silence missed");
	a_fire_resound: assert property (ce_i && fire_new |=> !bell_off_o && !aux_relay_off_o)
		else $error("bells not reactivated");
	a_fire_noop: assert property (ce_i && ev_ok && mode_fire && !(|cond_i.fire) && !(|off_v)
		|=> $stable(bell_off_o) && $stable(armed_reg) && $stable(burg_bell_block_o))
		else $error("short without fire changed state");
	a_hold_limit: assert property (ev_long |-> st_reg == kst_pkg::KS_HELD &&
		cnt_reg == HOLD_LAST) else $error("stay resolved before hold limit");
	a_tamper_lock: assert property (ce_i && ks_lock_reg && !(|off_v) |=> $stable(armed_reg))
		else $error("keyswitch acted while tampered");
	a_led_memory: assert property (ce_i && part_mode && mem_reg[psel] |=> !led_green_o)
		else $error("green lit with alarm memory");

	c_stay_arm: cover property (ce_i && rpt_arm && ev_long);
	c_alarm_silence: cover property (ce_i && |alm_v ##[1:1000] ce_i && |clr_v);
	c_fire_silence: cover property (ce_i && fs_hit);
	c_tamper: cover property (ks_lock_reg && (ev_short | ev_long));

endmodule

// [testbench/kst_ks_model.sv]
`timescale 1ns/1ns
// ==========================================================
// Keyswitch contact: closes for len_i cycles after go_i
module kst_ks_model (
	// Clock and press request
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [7:0] len_i,
	// Keyswitch zone contact
	output logic ks_short_o
);
	int cnt = 0;
	always @(posedge clk_i)
	begin
		if (go_i)
			cnt <= len_i;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
	assign ks_short_o = cnt > 0;
endmodule

// [testbench/keyswitch_and_trigger_outputs_tb.sv]
`timescale 1ns/1ns
module keyswitch_and_trigger_outputs_tb;
	// ==========================================================
	// Signals
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, ks, ac = 1'b0, snd = 1'b0;
	logic ce = 1'b1, tmp = 1'b0, in1 = 1'b0, ptx = 1'b0;
	logic [7:0] adr = 8'h00, len = 8'h00, ru;
	logic [31:0] dat = 32'h0, rdat, q;
	logic ack, red, green, boff, smoke, rstb;
	logic arl, bbl, prx, ain;
	logic [6:0] trg;
	logic [1:0] ssil;
	kst_pkg::kst_rpt_t rk, rpt_k;
	kst_pkg::kst_cond_t cond = '0;
	kst_pkg::kst_comm_t comm = '0;
	int fail_count = 0, cmp_count = 0, rpt_n = 0, smoke_n = 0, cyc_n = 0, n1, n2;
	always #10 clk_i = ~clk_i;
	// ==========================================================
	// Design and keyswitch
	kst_keyswitch #(.DEB_CYC(4), .HOLD_CYC(50), .FLASH_HALF_CYC(8)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .ks_short_i(ks), .ks_tamper_i(tmp), .ac_present_i(ac),
		.trig_in1_i(in1), .cond_i(cond), .comm_i(comm), .sounder_i(snd),
		.printer_txd_i(ptx), .trigger_header_o(trg), .led_red_o(red),
		.led_green_o(green), .bell_off_o(boff), .aux_relay_off_o(arl),
		.burg_bell_block_o(bbl), .sound_silence_o(ssil), .smoke_reset_o(smoke),
		.rpt_stb_o(rstb), .rpt_kind_o(rk), .rpt_user_o(ru), .printer_rxd_o(prx),
		.aux_in_o(ain));
	kst_ks_model ks_u (.clk_i(clk_i), .go_i(go), .len_i(len), .ks_short_o(ks));
	// ==========================================================
	// Monitors and timeout
	always @(negedge clk_i)
	begin
		if (rstb === 1'b1)
		begin
			rpt_n++;
			rpt_k = rk;
		end
		if (smoke === 1'b1)
			smoke_n++;
	end
	always @(posedge clk_i)
	begin
		cyc_n++;
		if (cyc_n == 20000)
		begin
			fail_count++;
			give_verdict();
		end
	end
	// ==========================================================
	// Tasks
	task automatic give_verdict();
		$display("Mismatches %0d, comparisons %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(negedge clk_i);
	endtask
	task automatic press(input logic [7:0] n);
		@(posedge clk_i);
		go <= 1'b1;
		len <= n;
		@(posedge clk_i);
		go <= 1'b0;
		wait_n(n + 12);
	endtask
	task automatic tog(output int n);
		logic p;
		n = 0;
		@(negedge clk_i);
		p = red;
		repeat (140)
		begin
			@(negedge clk_i);
			if (red !== p)
				n++;
			p = red;
		end
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk("trigger rst", 32'h0, trg);
		chk("printer rxd rst", 1, prx);
		wb(1'b0, 8'h00, 32'h0); chk("config rst", 32'h0, q);
		wb(1'b1, 8'h00, 32'h181); wb(1'b0, 8'h00, 32'h0); chk("config", 32'h181, q);
		wb(1'b0, 8'hfc, 32'h0); chk("unmapped", 32'h0, q);
		chk("open close disarmed", 1, trg[6]);
		chk("green ready", 1, green);
		press(8); wb(1'b0, 8'h08, 32'h0); chk("away", 32'h1, q[3:0]);
		chk("report away", {1'b1, kst_pkg::RPT_AWAY}, {rpt_n == 1, rpt_k});
		chk("report user", 32'h0, ru);
		chk("red steady", 32'h1, {green, red});
		chk("open close armed", 0, trg[6]);
		press(8); wb(1'b0, 8'h08, 32'h0); chk("disarm", 32'h0, q[3:0]);
		chk("report disarm", kst_pkg::RPT_DISARM, rpt_k);
		@(posedge clk_i);
		cond.fault[0] <= 1'b1;
		wait_n(2);
		chk("not ready", 32'h0, {green, red});
		press(8); wb(1'b0, 8'h08, 32'h0); chk("fault refuse", 32'h0, q[3:0]);
		@(posedge clk_i);
		cond.fault[0] <= 1'b0;
		press(80); wb(1'b0, 8'h08, 32'h0); chk("stay", 32'h5, q[3:0]);
		chk("report stay", kst_pkg::RPT_STAY, rpt_k);
		tog(n1); chk("slow flash", 1, n1 > 0);
		@(posedge clk_i);
		cond.alarm[0] <= 1'b1;
		cond.burg[0] <= 1'b1;
		wait_n(3);
		chk("burg trigger", 1, trg[1]);
		press(8); wb(1'b0, 8'h08, 32'h0); chk("silence", 32'h10, q[5:0]);
		chk("keypad silence", 1, ssil[0]);
		@(posedge clk_i);
		cond.alarm[0] <= 1'b0;
		tog(n2); chk("rapid flash", 1, n2 > n1);
		press(8); wb(1'b0, 8'h08, 32'h0); chk("mem clear", 32'h0, q[5:4]);
		chk("smoke reset", 1, smoke_n);
		@(posedge clk_i);
		cond.burg[0] <= 1'b0;
		wait_n(3);
		chk("burg latch", 1, trg[1]);
		wb(1'b1, 8'h04, 32'h1); chk("burg off", 0, trg[1]);
		@(posedge clk_i);
		cond.burg[1] <= 1'b1;
		wait_n(3);
		chk("burg disabled part", 0, trg[1]);
		@(posedge clk_i);
		cond.burg[1] <= 1'b0;
		snd <= 1'b1;
		wait_n(3);
		chk("sounder out5", 1, trg[4]);
		wb(1'b1, 8'h00, 32'h1c1);
		@(posedge clk_i);
		ptx <= 1'b1;
		in1 <= 1'b1;
		wait_n(4);
		chk("printer out2", 1, trg[1]);
		chk("printer rxd high", 1, prx);
		chk("aux in blocked", 0, ain);
		@(posedge clk_i);
		in1 <= 1'b0;
		wait_n(4);
		chk("printer rxd low", 0, prx);
		wb(1'b1, 8'h00, 32'h1a1);
		@(posedge clk_i);
		in1 <= 1'b1;
		ce <= 1'b0;
		ac <= 1'b1;
		wait_n(5);
		chk("frozen by enable", 0, {ain, trg[0]});
		@(posedge clk_i);
		ce <= 1'b1;
		wait_n(5);
		chk("mains on", 1, trg[0]);
		chk("aux in", 1, ain);
		@(posedge clk_i);
		ac <= 1'b0;
		wait_n(5);
		chk("mains off", 0, trg[0]);
		@(posedge clk_i);
		comm.tx_exhaust <= 1'b1;
		@(posedge clk_i);
		comm.tx_exhaust <= 1'b0;
		wb(1'b1, 8'h04, 32'h1); chk("comm fail held", 1, trg[2]);
		@(posedge clk_i);
		comm.tx_ok <= 1'b1;
		@(posedge clk_i);
		comm.tx_ok <= 1'b0;
		wb(1'b1, 8'h04, 32'h1); chk("comm fail off", 0, trg[2]);
		@(posedge clk_i);
		comm.line_fault[1] <= 1'b1;
		wait_n(2);
		chk("line fault on", 1, trg[4]);
		@(posedge clk_i);
		comm.line_fault[1] <= 1'b0;
		wait_n(2);
		chk("line fault held", 1, trg[4]);
		wb(1'b1, 8'h04, 32'h1); chk("line fault off", 0, trg[4]);
		@(posedge clk_i);
		tmp <= 1'b1;
		wait_n(4);
		@(posedge clk_i);
		tmp <= 1'b0;
		press(8); wb(1'b0, 8'h08, 32'h0); chk("tamper lock", 32'h800, q[11:0]);
		wb(1'b1, 8'h04, 32'h1); wb(1'b0, 8'h08, 32'h0); chk("tamper free", 0, q[11:0]);
		wb(1'b1, 8'h00, 32'h509);
		press(8); wb(1'b0, 8'h08, 32'h0); chk("no fire short", 32'h0, q[7:0]);
		chk("bell idle", 0, {arl, boff});
		@(posedge clk_i);
		cond.fire[0] <= 1'b1;
		wait_n(2);
		chk("fire trigger", 1, trg[0]);
		press(8); chk("fire silence", 32'h7, {arl, bbl, boff});
		@(posedge clk_i);
		cond.fire[1] <= 1'b1;
		wait_n(3);
		chk("new fire resound", 32'h2, {arl, bbl, boff});
		wb(1'b1, 8'h04, 32'h1); chk("burg bell release", 0, bbl);
		give_verdict();
	end
endmodule
